// ### cct16_timer.sv
// 16-bit capture/compare timer with one pulse and PWM modes
// Notes on behaviour
// - Wait mode: timer runs, interrupts wake device
// - Halt freezes counter; resumes or restarts
// - Halt capture edge arms; flags on wakeup
// - Every enabled, unmasked request wakes from Wait, never Halt
// - Shared request needs flag, enable, mask clear
// - No compare interrupt sources in PWM
// - Capture enable requests on either capture flag
// - Compare enable requests on either compare flag
// - Overflow enable requests on overflow flag
// - Force two copies level two to pin
// - Force one copies level one to pin
// - Level two on match two: pin two, or pin one in PWM
// - Capture one edge: 0 falling, 1 rising
// - Level one copied on compare one match
// - Pin one enable only connects the pin
// - Pin two enable only connects the pin
// - One pulse: edge starts pulse, length compare
// - PWM: compare one length, two period
// - Clock select 00/4, 01/2, 10/8
// - Code 11 uses external clock pin
// - Three control/status, six data pairs
// - Capture two edge: 0 falling, 1 rising
// - External clock edge: 0 falling, 1 rising
// - Flag clears: status read, then low access
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "cct16_regs.svh"

module cct16_timer
	import cct16_pkg::*;
#(
	parameter bit EXT_CLK_PRESENT = 1'b1    // Part has the external clock pin
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [7:0]  rdata,
	input  wire logic        halt_mode,
	input  wire logic        wait_mode,
	input  wire logic        global_irq_mask,
	input  wire logic        capture_input_pin_one,
	input  wire logic        capture_input_pin_two,
	input  wire logic        ext_timer_clock_pin,
	output logic             compare_output_pin_one,
	output logic             compare_output_pin_one_oe,
	output logic             compare_output_pin_two,
	output logic             compare_output_pin_two_oe,
	output logic             timer_irq,
	output logic             wait_wakeup
);

	// Tick when the prescaler has wrapped for the chosen ratio
	function automatic logic presc_tick(input logic [1:0] sel, input logic [2:0] p);
		case (sel)
			CCT16_CLK_DIV2: presc_tick = p[0];
			CCT16_CLK_DIV4: presc_tick = &p[1:0];
			CCT16_CLK_DIV8: presc_tick = &p[2:0];
			default:        presc_tick = 1'b0;
		endcase
	endfunction

	// Edge chooser: rising when sel is 1, falling when 0
	function automatic logic edge_of(input logic sel, input logic now, input logic was);
		edge_of = sel ? (now & ~was) : (~now & was);
	endfunction

	// Software state
	cct16_byte_t ctl_one_r;          // First control register
	cct16_byte_t ctl_two_r;          // Second control register
	logic        timer_off_r;        // Timer disable bit in status
	cct16_word_t cmp1_r, cmp2_r;     // Compare values as written
	cct16_word_t cmp1_sh_r, cmp2_sh_r; // PWM shadow copies
	logic        lock1_r, lock2_r;   // High byte written, low pending
	// Hardware state
	cct16_word_t cnt_r;              // Free running counter
	cct16_word_t cap1_r, cap2_r;     // Capture values
	logic [2:0]  presc_r;            // Prescaler
	logic        capture_flag_one_r, capture_flag_two_r, compare_flag_one_r, compare_flag_two_r, tof_r;   // Event flags
	logic [4:0]  arm_r;              // Clear step one seen, per flag
	logic        pend1_r, pend2_r;   // Capture edges seen during halt
	logic        halt_q_r;           // Halt level one cycle ago
	// Pin synchronisers; stage a is read only by stage b
	logic [2:0]  ic1_a_r, ic1_b_r;
	logic        ic1_c_r2;           // Edge history of capture one
	logic        ic2_a_r, ic2_b_r, ic2_c_r, ext_a_r, ext_b_r, ext_c_r;

	// Control fields
	wire logic       cap_ie    = ctl_one_r[`CCT16_B1_CAP_IE];
	wire logic       cmp_ie    = ctl_one_r[`CCT16_B1_CMP_IE];
	wire logic       ovf_ie    = ctl_one_r[`CCT16_B1_OVF_IE];
	wire logic       force_two = ctl_one_r[`CCT16_B1_FORCE2];
	wire logic       force_one = ctl_one_r[`CCT16_B1_FORCE1];
	wire logic       level_two = ctl_one_r[`CCT16_B1_LEVEL2];
	wire logic       edge_one  = ctl_one_r[`CCT16_B1_EDGE1];
	wire logic       level_one = ctl_one_r[`CCT16_B1_LEVEL1];
	wire logic       pin1_en   = ctl_two_r[`CCT16_B2_PIN1_EN];
	wire logic       pin2_en   = ctl_two_r[`CCT16_B2_PIN2_EN];
	wire logic       pwm_on    = ctl_two_r[`CCT16_B2_PWM];
	// PWM wins when both mode bits are set
	wire logic       opm_on    = ctl_two_r[`CCT16_B2_ONE_PULSE] & ~pwm_on;
	wire logic [1:0] clk_sel   = ctl_two_r[`CCT16_B2_CLK_HI:`CCT16_B2_CLK_LO];
	wire logic       edge_two  = ctl_two_r[`CCT16_B2_EDGE2];
	wire logic       ext_edge  = ctl_two_r[`CCT16_B2_EXT_EDGE];

	// Bus decode
	wire logic rd_status = rd_stb & (addr == `CCT16_ADR_STATUS);
	wire logic acc_cap1  = (rd_stb | wr_stb) & (addr == `CCT16_ADR_CAP1_LO);
	wire logic acc_cap2  = (rd_stb | wr_stb) & (addr == `CCT16_ADR_CAP2_LO);
	wire logic acc_cmp1  = (rd_stb | wr_stb) & (addr == `CCT16_ADR_CMP1_LO);
	wire logic acc_cmp2  = (rd_stb | wr_stb) & (addr == `CCT16_ADR_CMP2_LO);
	wire logic acc_cnt   = (rd_stb | wr_stb) & (addr == `CCT16_ADR_CNT_LO);
	wire logic wr_c1hi   = wr_stb & (addr == `CCT16_ADR_CMP1_HI);
	wire logic wr_c2hi   = wr_stb & (addr == `CCT16_ADR_CMP2_HI);
	wire logic wr_c1lo   = wr_stb & (addr == `CCT16_ADR_CMP1_LO);
	wire logic wr_c2lo   = wr_stb & (addr == `CCT16_ADR_CMP2_LO);
	// Either counter low byte restarts the count; only the main one clears overflow
	wire logic cnt_reset = wr_stb & ((addr == `CCT16_ADR_CNT_LO) | (addr == `CCT16_ADR_ACNT_LO));

	// Timebase
	wire logic frozen   = halt_mode | timer_off_r;
	wire logic ext_edge_seen = edge_of(ext_edge, ext_b_r, ext_c_r);
	wire logic ext_tick = EXT_CLK_PRESENT & ext_edge_seen;
	wire logic tick     = ~frozen & ((clk_sel == CCT16_CLK_EXT) ? ext_tick
	                                 : presc_tick(clk_sel, presc_r));

	// Capture edges and halt exit
	wire logic edge1     = edge_of(edge_one, ic1_b_r[0], ic1_c_r2);
	wire logic edge2     = edge_of(edge_two, ic2_b_r, ic2_c_r);
	wire logic halt_exit = halt_q_r & ~halt_mode;
	wire logic cap1_ev   = ~pwm_on & ((edge1 & ~halt_mode) | (halt_exit & pend1_r));
	wire logic cap2_ev   = (edge2 & ~halt_mode) | (halt_exit & pend2_r);
	wire logic opm_trig  = opm_on & edge1 & ~halt_mode;

	// Compare matches, shadowed in PWM
	wire cct16_word_t c1_eff = pwm_on ? cmp1_sh_r : cmp1_r;
	wire cct16_word_t c2_eff = pwm_on ? cmp2_sh_r : cmp2_r;
	wire logic m1       = tick & (cnt_r == c1_eff);
	wire logic m2       = tick & (cnt_r == c2_eff);
	wire logic pwm_end  = pwm_on & m2;
	wire logic ovf_ev   = tick & (cnt_r == 16'hFFFF) & ~pwm_end;

	// Flag set conditions
	wire logic set_capture_flag_one = cap1_ev | pwm_end | (opm_on & ~pwm_on & opm_trig);
	wire logic set_capture_flag_two = cap2_ev;
	wire logic set_compare_flag_one = m1 & ~pwm_on & ~opm_on & ~force_one;
	wire logic set_compare_flag_two = m2 & ~pwm_on & ~force_two;

	// Clear step two, gated by step one
	wire logic clr_capture_flag_one = arm_r[4] & acc_cap1;
	wire logic clr_compare_flag_one = arm_r[3] & acc_cmp1;
	wire logic clr_tof  = arm_r[2] & acc_cnt;
	wire logic clr_capture_flag_two = arm_r[1] & acc_cap2;
	wire logic clr_compare_flag_two = arm_r[0] & acc_cmp2;

	wire logic [4:0] flags = {capture_flag_one_r, compare_flag_one_r, tof_r, capture_flag_two_r, compare_flag_two_r};
	wire cct16_byte_t status = {flags, timer_off_r, 2'b00};

	// Next counter value
	cct16_word_t cnt_nxt;
	always_comb begin
		cnt_nxt = cnt_r;
		if (cnt_reset | opm_trig | pwm_end)   // Restart points
			cnt_nxt = `CCT16_RST_CNT;
		else if (tick)                        // Plain increment, wraps
			cnt_nxt = cnt_r + 16'h0001;
	end

	// Pin one level
	logic pin1_nxt;
	always_comb begin
		pin1_nxt = compare_output_pin_one;
		if (pwm_on) begin
			if (pwm_end)
				pin1_nxt = level_two;
			else if (m1)
				pin1_nxt = level_one;
		end else if (opm_on) begin
			if (opm_trig)
				pin1_nxt = level_two;
			else if (m1)
				pin1_nxt = level_one;
		end else if (force_one)
			pin1_nxt = level_one;
		else if (m1)
			pin1_nxt = level_one;
	end

	// Pin two level; level two belongs to pin one in the pulse modes
	wire logic pin2_nxt = (~pwm_on & ~opm_on & (force_two | m2)) ? level_two
	                      : compare_output_pin_two;

	// Interrupt request: shared line, global mask
	wire logic irq_nxt = ~global_irq_mask & (
	                       (cap_ie & (capture_flag_one_r | capture_flag_two_r)) |
	                       (cmp_ie & (compare_flag_one_r | compare_flag_two_r) & ~pwm_on) |
	                       (ovf_ie & tof_r));

	// Read mux, every register one byte
	cct16_byte_t rd_mux;
	always_comb begin
		case (addr)
			`CCT16_ADR_CTL_TWO: rd_mux = ctl_two_r;
			`CCT16_ADR_CTL_ONE: rd_mux = ctl_one_r;
			`CCT16_ADR_STATUS:  rd_mux = status;
			`CCT16_ADR_CAP1_HI: rd_mux = cap1_r[15:8];
			`CCT16_ADR_CAP1_LO: rd_mux = cap1_r[7:0];
			`CCT16_ADR_CMP1_HI: rd_mux = cmp1_r[15:8];
			`CCT16_ADR_CMP1_LO: rd_mux = cmp1_r[7:0];
			`CCT16_ADR_CNT_HI,
			`CCT16_ADR_ACNT_HI: rd_mux = cnt_r[15:8];
			`CCT16_ADR_CNT_LO,
			`CCT16_ADR_ACNT_LO: rd_mux = cnt_r[7:0];
			`CCT16_ADR_CAP2_HI: rd_mux = cap2_r[15:8];
			`CCT16_ADR_CAP2_LO: rd_mux = cap2_r[7:0];
			`CCT16_ADR_CMP2_HI: rd_mux = cmp2_r[15:8];
			`CCT16_ADR_CMP2_LO: rd_mux = cmp2_r[7:0];
			default:            rd_mux = 8'h00;   // Unmapped reads zero
		endcase
	end

	// Synchronisers and edge history
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ic1_a_r  <= 3'b000;
			ic1_b_r  <= 3'b000;
			ic1_c_r2 <= 1'b0;
			{ic2_a_r, ic2_b_r, ic2_c_r} <= 3'b000;
			{ext_a_r, ext_b_r, ext_c_r} <= 3'b000;
		end else begin
			ic1_a_r  <= {2'b00, capture_input_pin_one};
			ic1_b_r  <= ic1_a_r;
			ic1_c_r2 <= ic1_b_r[0];
			{ic2_a_r, ic2_b_r, ic2_c_r} <= {capture_input_pin_two, ic2_a_r, ic2_b_r};
			{ext_a_r, ext_b_r, ext_c_r} <= {ext_timer_clock_pin, ext_a_r, ext_b_r};
		end
	end

	// Software registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl_one_r   <= `CCT16_RST_CTL;
			ctl_two_r   <= `CCT16_RST_CTL;
			timer_off_r <= 1'b0;
		end else if (wr_stb) begin
			if (addr == `CCT16_ADR_CTL_ONE)
				ctl_one_r <= wdata;
			if (addr == `CCT16_ADR_CTL_TWO)
				ctl_two_r <= wdata;
			if (addr == `CCT16_ADR_STATUS)      // Only the disable bit is writable
				timer_off_r <= wdata[`CCT16_BS_TIMER_OFF];
		end
	end

	// Compare values, lock and PWM shadows
	// Shadow waits for period end so a half-written value never reaches the pin
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmp1_r    <= `CCT16_RST_CMP;
			cmp2_r    <= `CCT16_RST_CMP;
			cmp1_sh_r <= `CCT16_RST_CMP;
			cmp2_sh_r <= `CCT16_RST_CMP;
			lock1_r   <= 1'b0;
			lock2_r   <= 1'b0;
		end else begin
			if (wr_c1hi) cmp1_r[15:8] <= wdata;
			if (wr_c1lo) cmp1_r[7:0]  <= wdata;
			if (wr_c2hi) cmp2_r[15:8] <= wdata;
			if (wr_c2lo) cmp2_r[7:0]  <= wdata;
			lock1_r <= wr_c1hi | (lock1_r & ~wr_c1lo);
			lock2_r <= wr_c2hi | (lock2_r & ~wr_c2lo);
			if ((~pwm_on | pwm_end) & ~lock1_r)
				cmp1_sh_r <= cmp1_r;
			if ((~pwm_on | pwm_end) & ~lock2_r)
				cmp2_sh_r <= cmp2_r;
		end
	end

	// Prescaler, counter and captures; prescaler and count hold while frozen, captures held back until halt exit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			presc_r  <= 3'b000;
			cnt_r    <= `CCT16_RST_CNT;   // Reset wakeup restarts here
			cap1_r   <= `CCT16_RST_CAP;
			cap2_r   <= `CCT16_RST_CAP;
			halt_q_r <= 1'b0;
		end else begin
			if (!frozen)
				presc_r <= presc_r + 3'b001;
			cnt_r    <= cnt_nxt;
			halt_q_r <= halt_mode;
			if (cap1_ev | opm_trig)
				cap1_r <= cnt_r;
			if (cap2_ev)
				cap2_r <= cnt_r;
		end
	end

	// Event flags: set beats clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{capture_flag_one_r, compare_flag_one_r, tof_r, capture_flag_two_r, compare_flag_two_r} <= 5'b00000;
			arm_r   <= 5'b00000;
			pend1_r <= 1'b0;
			pend2_r <= 1'b0;
		end else begin
			capture_flag_one_r <= set_capture_flag_one | (capture_flag_one_r & ~clr_capture_flag_one);
			compare_flag_one_r <= set_compare_flag_one | (compare_flag_one_r & ~clr_compare_flag_one);
			tof_r  <= ovf_ev   | (tof_r  & ~clr_tof);
			capture_flag_two_r <= set_capture_flag_two | (capture_flag_two_r & ~clr_capture_flag_two);
			compare_flag_two_r <= set_compare_flag_two | (compare_flag_two_r & ~clr_compare_flag_two);
			// Step one stays armed until its flag drops
			arm_r  <= (arm_r | (rd_status ? flags : 5'b00000)) & flags;
			// Edges in halt arm the capture logic
			pend1_r <= (halt_mode & edge1) | (pend1_r & halt_mode);
			pend2_r <= (halt_mode & edge2) | (pend2_r & halt_mode);
		end
	end

	// Output flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata                     <= 8'h00;
			compare_output_pin_one    <= 1'b0;
			compare_output_pin_two    <= 1'b0;
			compare_output_pin_one_oe <= 1'b0;
			compare_output_pin_two_oe <= 1'b0;
			timer_irq                 <= 1'b0;
			wait_wakeup               <= 1'b0;
		end else begin
			rdata                     <= rd_stb ? rd_mux : 8'h00;
			compare_output_pin_one    <= pin1_nxt;
			compare_output_pin_two    <= pin2_nxt;
			compare_output_pin_one_oe <= pin1_en & ~timer_off_r;
			compare_output_pin_two_oe <= pin2_en & ~timer_off_r;
			timer_irq                 <= irq_nxt & ~halt_mode;
			wait_wakeup               <= irq_nxt & wait_mode;
		end
	end

endmodule // cct16_timer
`default_nettype wire

// ### cct16_regs.svh
// Register offsets, field positions and reset values of the capture/compare timer
`ifndef CCT16_REGS_SVH
`define CCT16_REGS_SVH
`define CCT16_ADR_CTL_TWO   8'h55
`define CCT16_ADR_CTL_ONE   8'h56
`define CCT16_ADR_STATUS    8'h57
`define CCT16_ADR_CAP1_HI   8'h58
`define CCT16_ADR_CAP1_LO   8'h59
`define CCT16_ADR_CMP1_HI   8'h5A
`define CCT16_ADR_CMP1_LO   8'h5B
`define CCT16_ADR_CNT_HI    8'h5C
`define CCT16_ADR_CNT_LO    8'h5D
`define CCT16_ADR_ACNT_HI   8'h5E
`define CCT16_ADR_ACNT_LO   8'h5F
`define CCT16_ADR_CAP2_HI   8'h60
`define CCT16_ADR_CAP2_LO   8'h61
`define CCT16_ADR_CMP2_HI   8'h62
`define CCT16_ADR_CMP2_LO   8'h63
`define CCT16_B1_CAP_IE     7
`define CCT16_B1_CMP_IE     6
`define CCT16_B1_OVF_IE     5
`define CCT16_B1_FORCE2     4
`define CCT16_B1_FORCE1     3
`define CCT16_B1_LEVEL2     2
`define CCT16_B1_EDGE1      1
`define CCT16_B1_LEVEL1     0
`define CCT16_B2_PIN1_EN    7
`define CCT16_B2_PIN2_EN    6
`define CCT16_B2_ONE_PULSE  5
`define CCT16_B2_PWM        4
`define CCT16_B2_CLK_HI     3
`define CCT16_B2_CLK_LO     2
`define CCT16_B2_EDGE2      1
`define CCT16_B2_EXT_EDGE   0
`define CCT16_BS_TIMER_OFF  2
`define CCT16_RST_CTL       8'h00
`define CCT16_RST_CNT       16'hFFFC
`define CCT16_RST_CMP       16'h8000
`define CCT16_RST_CAP       16'h0000
`endif

// ### cct16_pkg.sv
// Types shared by the capture/compare timer
package cct16_pkg;
	typedef logic [15:0] cct16_word_t;   // 16-bit timer quantity
	typedef logic [7:0]  cct16_byte_t;   // Bus data byte
	typedef enum logic [1:0] {
		CCT16_CLK_DIV4 = 2'b00,
		CCT16_CLK_DIV2 = 2'b01,
		CCT16_CLK_DIV8 = 2'b10,
		CCT16_CLK_EXT  = 2'b11
	} cct16_clk_e;
endpackage

// ### cct16_props.sv
// Port-level assertions for the capture/compare timer, bound to its top
`timescale 1ns/10ps
`default_nettype none
`include "cct16_regs.svh"
module cct16_props (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	input  wire logic [7:0] rdata,
	input  wire logic       halt_mode,
	input  wire logic       wait_mode,
	input  wire logic       global_irq_mask,
	input  wire logic       compare_output_pin_one,
	input  wire logic       compare_output_pin_one_oe,
	input  wire logic       compare_output_pin_two,
	input  wire logic       compare_output_pin_two_oe,
	input  wire logic       timer_irq,
	input  wire logic       wait_wakeup
);
	logic [7:0] ctl1_r;  // Shadow of control one
	logic [7:0] ctl2_r;  // Shadow of control two
	logic       timd_r;  // Shadow of the timer disable bit
	// Shadows follow bus writes, so no peeking inside the design
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl1_r <= 8'h00;
			ctl2_r <= 8'h00;
			timd_r <= 1'b0;
		end else if (wr_stb) begin
			if (addr == `CCT16_ADR_CTL_ONE) ctl1_r <= wdata;
			if (addr == `CCT16_ADR_CTL_TWO) ctl2_r <= wdata;
			if (addr == `CCT16_ADR_STATUS) timd_r <= wdata[2];
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_RD_IDLE: assert property (!$past(rd_stb) |-> rdata == 8'h00)
		else $error("read data not zero outside an answer");
	AST_RD_CTL_ONE: assert property (rd_stb && addr == `CCT16_ADR_CTL_ONE |=> rdata == $past(ctl1_r))
		else $error("control one read back wrong");
	AST_CNT_RESTART: assert property (wr_stb && addr == `CCT16_ADR_CNT_LO ##[1:4] rd_stb && addr == `CCT16_ADR_CNT_HI |=> rdata == 8'hFF)
		else $error("counter not restarted by low byte write");
	AST_IRQ_MASK: assert property (global_irq_mask |=> !timer_irq)
		else $error("request while globally masked");
	AST_IRQ_HALT: assert property (halt_mode |=> !timer_irq)
		else $error("request during halt");
	AST_IRQ_CAUSE: assert property (timer_irq |-> $past(ctl1_r[7:5]) != 3'b000)
		else $error("request with every enable clear");
	AST_WAKE_WAIT: assert property (!wait_mode |=> !wait_wakeup)
		else $error("wakeup outside wait");
	AST_OE_ONE: assert property (compare_output_pin_one_oe == ($past(ctl2_r[7]) && !$past(timd_r)))
		else $error("pin one enable wrong");
	AST_OE_TWO: assert property (compare_output_pin_two_oe == ($past(ctl2_r[6]) && !$past(timd_r)))
		else $error("pin two enable wrong");
	AST_FORCE_ONE: assert property (ctl1_r[3] && ctl2_r[7] && ctl2_r[5:4] == 2'b00 && !timd_r |=> compare_output_pin_one == $past(ctl1_r[0]))
		else $error("forced level one missing");
	AST_FORCE_TWO: assert property (ctl1_r[4] && ctl2_r[6] && ctl2_r[5:4] == 2'b00 && !timd_r |=> compare_output_pin_two == $past(ctl1_r[2]))
		else $error("forced level two missing");
	COV_IRQ: cover property (timer_irq);
	COV_WAKE: cover property (wait_wakeup);
	COV_PIN_RISE: cover property ($rose(compare_output_pin_one));
endmodule // cct16_props
bind cct16_timer cct16_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .halt_mode(halt_mode), .wait_mode(wait_mode),
	.global_irq_mask(global_irq_mask), .compare_output_pin_one(compare_output_pin_one),
	.compare_output_pin_one_oe(compare_output_pin_one_oe), .compare_output_pin_two(compare_output_pin_two),
	.compare_output_pin_two_oe(compare_output_pin_two_oe), .timer_irq(timer_irq), .wait_wakeup(wait_wakeup));
`default_nettype wire

// ### cct16_pins.sv
// Pin-side model: capture sources, external timer clock, pulse counter
`timescale 1ns/10ps
`default_nettype none
module cct16_pins (
	input  wire logic        clk_sys,
	input  wire logic        ext_run,   // Run the external clock
	input  wire logic [1:0]  cap_lvl,   // Wanted capture pin levels
	input  wire logic        pin_one,   // Compare pin one
	output var  logic        cap_one,
	output var  logic        cap_two,
	output var  logic        ext_clk,
	output var  logic [15:0] rise_cnt   // Rising edges on pin one
);
	logic [1:0] div_r = 2'b00;  // Half period count
	logic       pin_r = 1'b0;   // Last pin one level
	initial begin
		cap_one = 1'b1;
		cap_two = 1'b1;
		ext_clk = 1'b0;
		rise_cnt = 16'h0000;
	end
	// Pins move just after an edge; external clock stands still when idle
	always @(posedge clk_sys) begin
		cap_one <= cap_lvl[0];
		cap_two <= cap_lvl[1];
		div_r <= ext_run ? div_r + 2'd1 : 2'd0;
		if (ext_run && div_r == 2'd3) begin
			ext_clk <= ~ext_clk;
		end
		pin_r <= pin_one;
		if (pin_one && !pin_r) begin
			rise_cnt <= rise_cnt + 16'd1;
		end
	end
endmodule // cct16_pins
`default_nettype wire

// ### cct16_timer_bench.sv
// Self-checking bench for the capture/compare timer
`timescale 1ns/10ps
`default_nettype none
`include "cct16_regs.svh"
module cct16_timer_bench;
	import cct16_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	cct16_byte_t addr = 8'h00;
	cct16_byte_t wdata = 8'h00;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic        rd_q = 1'b0;    // Answer due this cycle
	logic        halt_mode = 1'b0;
	logic        wait_mode = 1'b0;
	logic        gmask = 1'b1;   // Global mask, high blocks
	logic        ext_run = 1'b0;
	logic [1:0]  cap_lvl = 2'b11;
	cct16_byte_t rdata;
	logic        p1, p1oe, p2, p2oe, irq, wake, cap1, cap2, extc;
	logic [15:0] rise_cnt;
	logic [15:0] n0;
	cct16_byte_t d;
	int          error_cnt = 0;
	int          checks = 0;
	int          dv[4] = '{4, 2, 8, 8};  // System clocks per tick, by clock code
	cct16_byte_t exp_q[$];               // Expected read data
	cct16_byte_t msk_q[$];               // Bits that matter
	always #25 clk_sys = ~clk_sys;
	cct16_timer dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .halt_mode(halt_mode), .wait_mode(wait_mode), .global_irq_mask(gmask),
		.capture_input_pin_one(cap1), .capture_input_pin_two(cap2), .ext_timer_clock_pin(extc),
		.compare_output_pin_one(p1), .compare_output_pin_one_oe(p1oe), .compare_output_pin_two(p2),
		.compare_output_pin_two_oe(p2oe), .timer_irq(irq), .wait_wakeup(wake));
	cct16_pins u_pins (.clk_sys(clk_sys), .ext_run(ext_run), .cap_lvl(cap_lvl), .pin_one(p1),
		.cap_one(cap1), .cap_two(cap2), .ext_clk(extc), .rise_cnt(rise_cnt));
	task automatic conclude;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (checks > 0 && error_cnt == 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input cct16_byte_t e, input cct16_byte_t g, input cct16_byte_t m);
		checks++;
		if ((g & m) !== (e & m)) begin
			error_cnt++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic pchk(input logic e, input logic g);
		chk({7'h00, e}, {7'h00, g}, 8'h01);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Strobe rises one edge after entry, so back-to-back calls never clash
	task automatic wr(input cct16_byte_t a, input cct16_byte_t v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input cct16_byte_t a, input cct16_byte_t e, input cct16_byte_t m);
		@(posedge clk_sys);
		exp_q.push_back(e);
		msk_q.push_back(m);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
	endtask
	// Answer stands one cycle; sample it mid-cycle against the oldest note
	always @(posedge clk_sys) rd_q <= rd_stb;
	always @(negedge clk_sys) begin
		if (rd_q) chk(exp_q.pop_front(), rdata, msk_q.pop_front());
	end
	initial begin
		cyc(20000);
		error_cnt++;
		conclude();
	end
	initial begin
		void'($urandom(32'h540fbe46));
		cyc(5);
		rst_n <= 1'b1;
		rd(`CCT16_ADR_CTL_ONE, 8'h00, 8'hFF);
		rd(`CCT16_ADR_CMP1_HI, 8'h80, 8'hFF);
		rd(`CCT16_ADR_CMP2_LO, 8'h00, 8'hFF);
		rd(`CCT16_ADR_STATUS, 8'h00, 8'hDF);
		rd(8'h70, 8'h00, 8'hFF);
		d = 8'($urandom) & 8'hE7;
		wr(`CCT16_ADR_CTL_ONE, d);
		rd(`CCT16_ADR_CTL_ONE, d, 8'hFF);
		// Every clock code: restart, then probe before and after the wrap
		ext_run <= 1'b1;
		foreach (dv[i]) begin
			wr(`CCT16_ADR_CTL_TWO, {4'h0, 2'(i), 2'b01});
			wr(`CCT16_ADR_CNT_LO, 8'h00);
			cyc(2 * dv[i] - 2);
			rd(`CCT16_ADR_CNT_HI, 8'hFF, 8'hFF);
			cyc(4 * dv[i] - 2);
			rd(`CCT16_ADR_CNT_HI, 8'h00, 8'hFF);
		end
		ext_run <= 1'b0;
		wr(`CCT16_ADR_CTL_ONE, 8'h20);
		gmask <= 1'b0;
		cyc(3);
		wait_mode <= 1'b1;
		cyc(3);
		@(negedge clk_sys);
		pchk(1'b1, irq);
		pchk(1'b1, wake);
		cyc(1);
		wait_mode <= 1'b0;
		rd(`CCT16_ADR_STATUS, 8'h20, 8'h20);
		wr(`CCT16_ADR_ACNT_LO, 8'h00);
		rd(`CCT16_ADR_STATUS, 8'h20, 8'h20);
		wr(`CCT16_ADR_CNT_LO, 8'h00);
		rd(`CCT16_ADR_STATUS, 8'h00, 8'h20);
		cyc(60);
		rd(`CCT16_ADR_CNT_HI, 8'hFF, 8'hFF);
		// Plain compare on both pins, then force both low
		wr(`CCT16_ADR_CTL_TWO, 8'hC4);
		wr(`CCT16_ADR_CMP1_HI, 8'h00);
		wr(`CCT16_ADR_CMP1_LO, 8'h00);
		wr(`CCT16_ADR_CMP2_HI, 8'h00);
		wr(`CCT16_ADR_CMP2_LO, 8'h01);
		wr(`CCT16_ADR_CTL_ONE, 8'h45);
		wr(`CCT16_ADR_CNT_LO, 8'h00);
		cyc(16);
		@(negedge clk_sys);
		pchk(1'b1, p1);
		pchk(1'b1, p2);
		pchk(1'b1, irq);
		rd(`CCT16_ADR_STATUS, 8'h48, 8'h48);
		wr(`CCT16_ADR_CTL_ONE, 8'h18);
		cyc(3);
		@(negedge clk_sys);
		pchk(1'b0, p1);
		pchk(1'b0, p2);
		cyc(1);
		cap_lvl <= 2'b00;
		cyc(8);
		rd(`CCT16_ADR_STATUS, 8'h10, 8'h10);
		// Single pulse: a falling edge must not fire, a rising one must
		wr(`CCT16_ADR_CMP1_LO, 8'h10);
		wr(`CCT16_ADR_CTL_ONE, 8'h06);
		wr(`CCT16_ADR_CTL_TWO, 8'hA4);
		cap_lvl <= 2'b01;
		cyc(8);
		@(negedge clk_sys);
		pchk(1'b1, p1);
		cyc(50);
		@(negedge clk_sys);
		pchk(1'b0, p1);
		cap_lvl <= 2'b00;
		cyc(8);
		@(negedge clk_sys);
		pchk(1'b0, p1);
		// Waveform; status read plus low byte writes clear old compare flags
		rd(`CCT16_ADR_STATUS, 8'h00, 8'h00);
		wr(`CCT16_ADR_CMP1_LO, 8'h04);
		wr(`CCT16_ADR_CMP2_LO, 8'h10);
		wr(`CCT16_ADR_CTL_TWO, 8'h94);
		// Restart to FFFC just short of the wrap, else the first match is a full wrap away
		wr(`CCT16_ADR_CNT_LO, 8'h00);
		cyc(40);
		n0 = rise_cnt;
		cyc(420);
		pchk(1'b1, (rise_cnt - n0) >= 16'd9 && (rise_cnt - n0) <= 16'd11);
		rd(`CCT16_ADR_STATUS, 8'h80, 8'hC8);
		// Halt freezes the counter just after a restart
		wr(`CCT16_ADR_CTL_TWO, 8'h04);
		wr(`CCT16_ADR_CNT_LO, 8'h00);
		halt_mode <= 1'b1;
		cyc(60);
		rd(`CCT16_ADR_CNT_HI, 8'hFF, 8'hFF);
		halt_mode <= 1'b0;
		cyc(4);
		conclude();
	end
endmodule // cct16_timer_bench
`default_nettype wire
